// file: shared/timer_pkg.sv
package timer_pkg;

	// -----------------------------------------------------------------
	// Register addresses on the special function register bus
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h91;
	localparam logic [7:0] ADDR_RLL  = 8'h92;
	localparam logic [7:0] ADDR_RLH  = 8'h93;
	localparam logic [7:0] ADDR_CNTL = 8'h94;
	localparam logic [7:0] ADDR_CNTH = 8'h95;

	// -----------------------------------------------------------------
	// Control register field positions and reset values
	// -----------------------------------------------------------------
	localparam int CTRL_OVF  = 7;
	localparam int CTRL_RUN  = 2;
	localparam int CTRL_DIV  = 1;
	localparam int CTRL_XCLK = 0;

	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] COUNT_ALL1   = 16'hFFFF;
	localparam logic [7:0]  READ_UNMAPPED = 8'h00;

	// -----------------------------------------------------------------
	// Divider terminal counts
	// -----------------------------------------------------------------
	localparam logic [3:0] SYS_DIV_LAST = 4'hB;
	localparam logic [2:0] EXT_DIV_LAST = 3'h7;

	// -----------------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sfr_req_s;

	typedef struct packed {
		logic       ovf_flag;
		logic       run_control;
		logic       sysclk_divide_select;
		logic       external_clock_select;
		logic [15:0] reload;
		logic [15:0] count;
		logic [3:0] presc;
		logic [7:0] rdata;
		logic       ovf_event;
		logic       irq;
	} timer_state_s;

	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       prev;
		logic [2:0] cnt;
		logic       tick;
	} ext_div_state_s;

endpackage : timer_pkg

// file: core/ext_osc_divider.sv
`timescale 1ns/1ps

module ext_osc_divider (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic ext_osc,
	input  wire logic enable,
	output logic      tick
);

	timer_pkg::ext_div_state_s s_q;
	timer_pkg::ext_div_state_s s_d;

	// -----------------------------------------------------------------
	// Synchroniser, edge detector and divide by eight
	// -----------------------------------------------------------------
	// The oscillator is sampled, so it must run below half of core_clk.
	always_comb begin
		s_d       = s_q;
		s_d.sync1 = ext_osc;
		s_d.sync2 = s_q.sync1;
		s_d.prev  = s_q.sync2;
		s_d.tick  = 1'b0;
		if (!enable) begin
			s_d.cnt = '0;
		end else if (s_q.sync2 && !s_q.prev) begin
			s_d.cnt  = s_q.cnt + 3'h1;
			s_d.tick = (s_q.cnt == timer_pkg::EXT_DIV_LAST);
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_tick_spacing: assert property (@(posedge core_clk) disable iff (!nrst)
		s_q.tick |=> !s_q.tick [*7])
		else $error("external divider ticks too close together");

endmodule : ext_osc_divider

// file: core/auto_reload_timer_16bit.sv
`timescale 1ns/1ps

module auto_reload_timer_16bit (
	input  wire logic                core_clk,
	input  wire logic                nrst,
	input  wire timer_pkg::sfr_req_s sfr_req,
	input  wire logic                irq_enable,
	input  wire logic                ext_osc,
	output logic [7:0]               sfr_rdata,
	output logic                     irq_req,
	output logic                     ovf_event
);

	timer_pkg::timer_state_s s_q;
	timer_pkg::timer_state_s s_d;
	logic                    ext_tick;
	logic                    sys_tick;
	logic                    step;
	logic                    wrap;
	logic [7:0]              ctrl_view;

	function automatic logic wr_hit(input timer_pkg::sfr_req_s r, input logic [7:0] a);
		wr_hit = r.wr && (r.addr == a);
	endfunction : wr_hit

	// -----------------------------------------------------------------
	// Clock sources
	// -----------------------------------------------------------------
	// The external path is oversampled on core_clk, so the counter keeps one
	// clock while the oscillator stays independent of the system clock choice.
	ext_osc_divider u_ext_div (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ext_osc  (ext_osc),
		.enable   (s_q.external_clock_select),
		.tick     (ext_tick)
	);

	always_comb begin
		// Run control only gates the step, so the prescaler keeps its phase while
		// the timer is stopped.
		sys_tick = s_q.sysclk_divide_select ||
			(s_q.presc == timer_pkg::SYS_DIV_LAST);
		step = 1'b0;
		if (s_q.run_control) begin
			// No pin event path exists; only clock-derived ticks count, from the prescaler or from the oscillator divider.
			step = s_q.external_clock_select ? ext_tick : sys_tick;
		end
		wrap = step && (s_q.count == timer_pkg::COUNT_ALL1);
		ctrl_view = {s_q.ovf_flag, 4'h0, s_q.run_control,
			s_q.sysclk_divide_select, s_q.external_clock_select};
	end

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		s_d           = s_q;
		s_d.ovf_event = 1'b0;
		// The prescaler free-runs, so the first divided step after run is set comes
		// one to twelve cycles later; this keeps the path short at that cost.
		s_d.presc     = (s_q.presc == timer_pkg::SYS_DIV_LAST) ? 4'h0 : s_q.presc + 4'h1;

		if (wr_hit(sfr_req, timer_pkg::ADDR_CTRL)) begin
			s_d.ovf_flag              = sfr_req.wdata[timer_pkg::CTRL_OVF];
			s_d.run_control           = sfr_req.wdata[timer_pkg::CTRL_RUN];
			s_d.sysclk_divide_select  = sfr_req.wdata[timer_pkg::CTRL_DIV];
			s_d.external_clock_select = sfr_req.wdata[timer_pkg::CTRL_XCLK];
		end
		// Reload bytes are written one at a time; an overflow that lands between the
		// two writes reloads a mixed value.
		if (wr_hit(sfr_req, timer_pkg::ADDR_RLL)) begin
			s_d.reload[7:0] = sfr_req.wdata;
		end
		if (wr_hit(sfr_req, timer_pkg::ADDR_RLH)) begin
			s_d.reload[15:8] = sfr_req.wdata;
		end

		if (wrap) begin
			s_d.count     = s_q.reload;
			s_d.ovf_flag  = 1'b1;
			s_d.ovf_event = 1'b1;
		end else if (step) begin
			s_d.count = s_q.count + 16'h0001;
		end

		// A software write to the count bytes wins over a step in the same cycle.
		if (wr_hit(sfr_req, timer_pkg::ADDR_CNTL)) begin
			s_d.count[7:0] = sfr_req.wdata;
		end
		if (wr_hit(sfr_req, timer_pkg::ADDR_CNTH)) begin
			s_d.count[15:8] = sfr_req.wdata;
		end

		// The request follows the next flag value, so it rises with the flag, while
		// a change of the mask takes one cycle to show.
		s_d.irq = s_d.ovf_flag && irq_enable;

		// Count bytes are read with no latch, so a 16-bit read of a running counter
		// can tear between the two byte reads.
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				timer_pkg::ADDR_CTRL: s_d.rdata = ctrl_view;
				timer_pkg::ADDR_RLL:  s_d.rdata = s_q.reload[7:0];
				timer_pkg::ADDR_RLH:  s_d.rdata = s_q.reload[15:8];
				timer_pkg::ADDR_CNTL: s_d.rdata = s_q.count[7:0];
				timer_pkg::ADDR_CNTH: s_d.rdata = s_q.count[15:8];
				default:              s_d.rdata = timer_pkg::READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			// Control fields take the reset word bit by bit, so a new reset word reaches all.
			s_q                       <= '0;
			s_q.ovf_flag              <= timer_pkg::CTRL_RESET[timer_pkg::CTRL_OVF];
			s_q.run_control           <= timer_pkg::CTRL_RESET[timer_pkg::CTRL_RUN];
			s_q.sysclk_divide_select  <= timer_pkg::CTRL_RESET[timer_pkg::CTRL_DIV];
			s_q.external_clock_select <= timer_pkg::CTRL_RESET[timer_pkg::CTRL_XCLK];
			s_q.reload                <= timer_pkg::RELOAD_RESET;
			s_q.count                 <= timer_pkg::COUNT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign sfr_rdata = s_q.rdata;
	assign irq_req   = s_q.irq;
	assign ovf_event = s_q.ovf_event;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	logic ctrl_wr;
	logic cnt_wr;
	logic rl_wr;
	assign ctrl_wr = wr_hit(sfr_req, timer_pkg::ADDR_CTRL);
	assign cnt_wr  = wr_hit(sfr_req, timer_pkg::ADDR_CNTL) || wr_hit(sfr_req, timer_pkg::ADDR_CNTH);
	assign rl_wr   = wr_hit(sfr_req, timer_pkg::ADDR_RLL) || wr_hit(sfr_req, timer_pkg::ADDR_RLH);

	// A software write wins over the counter in its own cycle, so checks on the
	// counter leave those cycles out.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_wrap_reload: assert property (wrap && !cnt_wr |=> s_q.count == $past(s_q.reload))
		else $error("counter not reloaded on overflow");
	a_wrap_flag: assert property (wrap |=> s_q.ovf_flag && ovf_event)
		else $error("overflow did not set flag and event");
	a_flag_sticky: assert property (s_q.ovf_flag && !ctrl_wr |=> s_q.ovf_flag)
		else $error("overflow flag cleared without software");
	a_event_flag: assert property (ovf_event |-> s_q.ovf_flag)
		else $error("overflow event without flag");
	a_irq_raise: assert property (s_q.ovf_flag && irq_enable && !ctrl_wr |=> irq_req)
		else $error("interrupt not requested");
	a_irq_cause: assert property (irq_req |-> s_q.ovf_flag)
		else $error("interrupt without overflow flag");
	a_stop_hold: assert property (!s_q.run_control && !cnt_wr |=> $stable(s_q.count))
		else $error("counter moved while stopped");
	a_div12_gap: assert property (step && !s_q.sysclk_divide_select
		&& !s_q.external_clock_select && !ctrl_wr |=> !step [*8])
		else $error("divide by twelve stepped too fast");
	a_ext_only: assert property (s_q.external_clock_select && !ext_tick |-> !step)
		else $error("external source stepped without oscillator tick");
	a_reserved_read: assert property (sfr_req.rd && sfr_req.addr == timer_pkg::ADDR_CTRL
		|=> sfr_rdata[6:3] == 4'h0)
		else $error("reserved control bits read nonzero");

	// -----------------------------------------------------------------
	// Further checks
	// -----------------------------------------------------------------
	a_count_step: assert property (step && !wrap && !cnt_wr
		|=> s_q.count == $past(s_q.count) + 16'h0001)
		else $error("counter did not advance by one");
	a_count_read: assert property (sfr_req.rd && sfr_req.addr == timer_pkg::ADDR_CNTL
		|=> sfr_rdata == $past(s_q.count[7:0]))
		else $error("count low byte read back wrong");
	a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
		else $error("read data changed without a read");
	a_reload_hold: assert property (!rl_wr |=> $stable(s_q.reload))
		else $error("reload value changed without a write");
	a_ext_ignore_div: assert property (s_q.run_control && s_q.external_clock_select
		|-> step == ext_tick)
		else $error("external source not followed");
	a_fast_step: assert property (s_q.run_control && s_q.sysclk_divide_select
		&& !s_q.external_clock_select |-> step)
		else $error("undivided clock did not step");
	a_div12_step: assert property (step && !s_q.external_clock_select
		|-> s_q.sysclk_divide_select || s_q.presc == timer_pkg::SYS_DIV_LAST)
		else $error("divided clock stepped off the prescaler end");
	a_flag_wins: assert property (wrap && ctrl_wr |=> s_q.ovf_flag)
		else $error("software clear beat an overflow");
	a_irq_mask: assert property (!irq_enable |=> !irq_req)
		else $error("interrupt requested while masked");
	a_run_write: assert property (ctrl_wr
		|=> s_q.run_control == $past(sfr_req.wdata[timer_pkg::CTRL_RUN]))
		else $error("run control did not take the written value");
	a_event_cause: assert property (ovf_event |-> $past(wrap))
		else $error("overflow event without a wrap");

	// The covers mark the scenarios that the bench is expected to reach.
	c_overflow: cover property (wrap);
	c_irq: cover property (irq_req);
	c_ext_step: cover property (s_q.external_clock_select && step);
	c_fast_wrap: cover property (s_q.sysclk_divide_select && wrap);
	c_div12_wrap: cover property (!s_q.sysclk_divide_select && !s_q.external_clock_select && wrap);

endmodule : auto_reload_timer_16bit

// file: bench/sfr_cpu_model.sv
`timescale 1ns/1ps

module sfr_cpu_model (
	input  wire logic           core_clk,
	input  wire logic [7:0]     sfr_rdata,
	output timer_pkg::sfr_req_s sfr_req
);
	// One-cycle strobes launched on the falling edge.
	// Released fields carry inverted values so that stale data is never read.
	initial sfr_req = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge core_clk);
		sfr_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge core_clk);
		d = sfr_rdata;
		sfr_req = '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
	endtask : rd
endmodule : sfr_cpu_model

// file: bench/tb_auto_reload_timer_16bit.sv
`timescale 1ns/1ps

module tb_auto_reload_timer_16bit;
	logic                core_clk;
	logic                nrst;
	logic                irq_enable;
	logic                ext_osc;
	logic [7:0]          sfr_rdata;
	logic                irq_req;
	logic                ovf_event;
	timer_pkg::sfr_req_s sfr_req;
	int                  mismatches;
	int                  cmp_count;
	logic [7:0]          d0;
	logic [7:0]          d1;
	int                  n;
	logic [7:0]          r_addr[6] = '{8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'hA0};
	logic [7:0]          r_wdat[6] = '{8'h78, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'hFF};
	logic [7:0]          r_exp[6]  = '{8'h00, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h00};
	logic [7:0]          m_ctrl[4] = '{8'h06, 8'h04, 8'h05, 8'h07};
	int                  m_gap[4]  = '{1, 12, 48, 48};

	sfr_cpu_model u_sfr_cpu_model (
		.core_clk  (core_clk),
		.sfr_rdata (sfr_rdata),
		.sfr_req   (sfr_req)
	);

	auto_reload_timer_16bit u_auto_reload_timer_16bit (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.sfr_req    (sfr_req),
		.irq_enable (irq_enable),
		.ext_osc    (ext_osc),
		.sfr_rdata  (sfr_rdata),
		.irq_req    (irq_req),
		.ovf_event  (ovf_event)
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Free-running oscillator, 120 ns period, phase offset from the core clock.
	initial begin
		ext_osc = 1'b0;
		#7;
		forever #60 ext_osc = ~ext_osc;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	task automatic do_reset;
		nrst = 1'b0;
		repeat (4) @(negedge core_clk);
		nrst = 1'b1;
	endtask : do_reset

	// Counts cycles from one overflow pulse to the next; the bound cuts a hang.
	task automatic gap(output int g);
		g = 0;
		while (ovf_event !== 1'b1 && g < 600) begin
			@(negedge core_clk);
			g++;
		end
		if (g >= 600) begin
			mismatches++;
			conclude();
		end
		g = 0;
		do begin
			@(negedge core_clk);
			g++;
		end while (ovf_event !== 1'b1 && g < 600);
		if (g >= 600) begin
			mismatches++;
			conclude();
		end
	endtask : gap

	// Two writes: an overflow landing with the first one keeps the flag set.
	task automatic stop;
		u_sfr_cpu_model.wr(8'h91, 8'h00);
		u_sfr_cpu_model.wr(8'h91, 8'h00);
	endtask : stop

	task automatic load(input logic [7:0] rl, input logic [7:0] ctl);
		u_sfr_cpu_model.wr(8'h92, rl);
		u_sfr_cpu_model.wr(8'h93, 8'hFF);
		u_sfr_cpu_model.wr(8'h94, 8'hFF);
		u_sfr_cpu_model.wr(8'h95, 8'hFF);
		u_sfr_cpu_model.wr(8'h91, ctl);
	endtask : load

	initial begin
		mismatches = 0;
		cmp_count  = 0;
		irq_enable = 1'b0;
		do_reset();
		for (int i = 0; i < 6; i++) begin
			u_sfr_cpu_model.wr(r_addr[i], r_wdat[i]);
			u_sfr_cpu_model.rd(r_addr[i], d0);
			check("register", {8'h00, d0}, {8'h00, r_exp[i]});
		end
		$display("Test register access done");
		for (int i = 0; i < 4; i++) begin
			stop();
			load(8'hFF, m_ctrl[i]);
			gap(n);
			check("overflow spacing", n[15:0], m_gap[i][15:0]);
		end
		$display("Test clock sources done");
		stop();
		irq_enable = 1'b1;
		load(8'hF0, 8'h06);
		gap(n);
		check("reload period", n[15:0], 16'h0010);
		u_sfr_cpu_model.rd(8'h91, d0);
		check("control", {8'h00, d0}, 16'h0086);
		check("irq", {15'h0000, irq_req}, 16'h0001);
		irq_enable = 1'b0;
		repeat (3) @(negedge core_clk);
		check("irq masked", {15'h0000, irq_req}, 16'h0000);
		u_sfr_cpu_model.rd(8'h95, d0);
		check("count high", {8'h00, d0}, 16'h00FF);
		stop();
		u_sfr_cpu_model.rd(8'h91, d0);
		check("flag cleared", {8'h00, d0}, 16'h0000);
		u_sfr_cpu_model.rd(8'h94, d0);
		repeat (20) @(negedge core_clk);
		u_sfr_cpu_model.rd(8'h94, d1);
		check("stopped", {8'h00, d1}, {8'h00, d0});
		$display("Test overflow done");
		load(8'hFF, 8'h06);
		do_reset();
		check("event in reset", {15'h0000, ovf_event}, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			u_sfr_cpu_model.rd(r_addr[i], d0);
			check("reset value", {8'h00, d0}, 16'h0000);
		end
		$display("Test reset done");
		conclude();
	end
endmodule : tb_auto_reload_timer_16bit
